// ---- core/dcos_defines.svh ----
// Timing figures and command bit positions of the command output stage.
`ifndef DCOS_DEFINES_SVH
`define DCOS_DEFINES_SVH

`define DCOS_CLK_PERIOD_NS 10
`define DCOS_MCLK_PERIOD_NS 125
`define DCOS_QTR_DEFAULT_CYC ((`DCOS_MCLK_PERIOD_NS / 4) / `DCOS_CLK_PERIOD_NS)
`define DCOS_CMD_W 3
`define DCOS_BIT_ROW 2
`define DCOS_BIT_COL 1
`define DCOS_BIT_WE 0
`define DCOS_NUM_COPIES 2
`define DCOS_NUM_CLK_PAIRS 6
`define DCOS_CNT_W 8
`define DCOS_CMD_IDLE_N 3'h7

`endif

// ---- core/dcos_pkg.sv ----
// Types shared by the command output stage.
package dcos_pkg;

    // Command request from the sequencer; each bit is one when asserted.
    typedef struct packed {
        logic row;
        logic col;
        logic we;
    } dcos_cmd_t;

    typedef enum logic [0:0] {
        DCOS_ST_IDLE,
        DCOS_ST_WAIT
    } dcos_state_t;

endpackage

// ---- core/dcos_cmd_out.sv ----
// Command line drivers and gated memory clock pairs.
//
// Summary of operation
// R1: Command is three active-low lines: row strobe, column strobe, write enable.
// R2: Every command line leaves as two copies, A and B, always equal.
// R3: During reset every command line copy is held high, negated.
// R4: Command lines change a quarter memory clock period after its rising edge.
// R5: Commands are launched against the memory clock, one per clock period.
// R6: Six differential clock pairs, five down to zero, each disabled on its own.
// R7: Disabled pair rests true low, complement high; restarts on a full period.
`timescale 1ns/1ps
`include "dcos_defines.svh"

module dcos_cmd_out
    import dcos_pkg::*;
#(
    parameter int CNT_W = `DCOS_CNT_W,
    parameter int NUM_PAIRS = `DCOS_NUM_CLK_PAIRS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic mem_clk,
    input wire logic cmd_valid,
    input wire dcos_cmd_t cmd,
    input wire logic [NUM_PAIRS-1:0] clk_pair_en,
    output logic cmd_ready,
    output logic row_strobe_copy_a_n,
    output logic row_strobe_copy_b_n,
    output logic col_strobe_copy_a_n,
    output logic col_strobe_copy_b_n,
    output logic write_enable_copy_a_n,
    output logic write_enable_copy_b_n,
    output logic [NUM_PAIRS-1:0] mem_clk_pair_true,
    output logic [NUM_PAIRS-1:0] mem_clk_pair_comp
);

    localparam logic [CNT_W-1:0] QTR_DEFAULT = CNT_W'(`DCOS_QTR_DEFAULT_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // Converts an asserted-high request into the active-low line levels.
    function automatic logic [`DCOS_CMD_W-1:0] cmd_to_lines_n(input dcos_cmd_t c);
        logic [`DCOS_CMD_W-1:0] v;
        v = `DCOS_CMD_IDLE_N;
        v[`DCOS_BIT_ROW] = ~c.row;
        v[`DCOS_BIT_COL] = ~c.col;
        v[`DCOS_BIT_WE] = ~c.we;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Memory clock sampling.

    logic mclk_s1_q;
    logic mclk_s2_q;
    logic mclk_s3_q;
    logic mclk_rise;
    logic mclk_fall;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_s3_q <= 1'b0;
        end else begin
            mclk_s1_q <= mem_clk;
            mclk_s2_q <= mclk_s1_q;
            mclk_s3_q <= mclk_s2_q;
        end
    end

    assign mclk_rise = mclk_s2_q & ~mclk_s3_q;
    assign mclk_fall = ~mclk_s2_q & mclk_s3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Period measurement, so the quarter delay follows the real memory clock.

    logic [CNT_W-1:0] per_cnt_q;
    logic [CNT_W-1:0] period_q;
    logic per_valid_q;
    logic per_seen_q;
    logic [CNT_W-1:0] qtr_cyc;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            per_cnt_q <= '0;
            period_q <= '0;
            per_valid_q <= 1'b0;
            per_seen_q <= 1'b0;
        end else if (mclk_rise) begin
            per_cnt_q <= '0;
            period_q <= (per_cnt_q == CNT_MAX) ? CNT_MAX : per_cnt_q + 1'b1;
            per_seen_q <= 1'b1;
            // The count up to the first rise after reset covers only part of a period.
            per_valid_q <= per_seen_q;
        end else if (per_cnt_q != CNT_MAX) begin
            per_cnt_q <= per_cnt_q + 1'b1;
        end
    end

    // The first period after reset is not yet known, so the nominal quarter is used.
    always_comb begin
        qtr_cyc = per_valid_q ? (period_q >> 2) : QTR_DEFAULT;
        if (qtr_cyc == '0) begin
            qtr_cyc = CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Launch timing.

    dcos_state_t state_q;
    logic [CNT_W-1:0] dly_q;
    logic launch;

    assign launch = (state_q == DCOS_ST_WAIT) && (dly_q == CNT_W'(1));

    // R4 quarter period delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= DCOS_ST_IDLE;
            dly_q <= '0;
        end else begin
            case (state_q)
                DCOS_ST_IDLE: begin
                    if (mclk_rise) begin
                        state_q <= DCOS_ST_WAIT;
                        dly_q <= qtr_cyc;
                    end
                end
                DCOS_ST_WAIT: begin
                    if (launch) begin
                        state_q <= DCOS_ST_IDLE;
                    end
                    dly_q <= dly_q - 1'b1;
                end
                default: begin
                    state_q <= DCOS_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pending command holding register.

    dcos_cmd_t pend_cmd_q;
    logic pend_v_q;
    logic pend_v_d;
    logic accept;

    assign accept = cmd_valid & cmd_ready;

    // R5 one command per period
    always_comb begin
        pend_v_d = pend_v_q;
        if (launch) begin
            pend_v_d = 1'b0;
        end
        if (accept) begin
            pend_v_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_v_q <= 1'b0;
            pend_cmd_q <= '0;
            cmd_ready <= 1'b1;
        end else begin
            pend_v_q <= pend_v_d;
            cmd_ready <= ~pend_v_d;
            if (accept) begin
                pend_cmd_q <= cmd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command line copies.

    logic [`DCOS_CMD_W-1:0] lines_n_q [`DCOS_NUM_COPIES];

    for (genvar k = 0; k < `DCOS_NUM_COPIES; k++) begin : g_copy
        // R3 negated under reset
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                lines_n_q[k] <= `DCOS_CMD_IDLE_N;
            end else if (launch) begin
                // R2 identical copies
                lines_n_q[k] <= pend_v_q ? cmd_to_lines_n(pend_cmd_q) : `DCOS_CMD_IDLE_N;
            end
        end
    end

    // R1 three line command
    assign row_strobe_copy_a_n = lines_n_q[0][`DCOS_BIT_ROW];
    assign col_strobe_copy_a_n = lines_n_q[0][`DCOS_BIT_COL];
    assign write_enable_copy_a_n = lines_n_q[0][`DCOS_BIT_WE];
    assign row_strobe_copy_b_n = lines_n_q[1][`DCOS_BIT_ROW];
    assign col_strobe_copy_b_n = lines_n_q[1][`DCOS_BIT_COL];
    assign write_enable_copy_b_n = lines_n_q[1][`DCOS_BIT_WE];

    ////////////////////////////////////////////////////////////////////////////////
    // Memory clock pairs.

    logic [NUM_PAIRS-1:0] pair_on_q;
    logic [NUM_PAIRS-1:0] pair_on_d;

    // R7 switch on at a rise, off at a fall
    always_comb begin
        pair_on_d = pair_on_q;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (mclk_rise && clk_pair_en[i]) begin
                pair_on_d[i] = 1'b1;
            end else if (mclk_fall && !clk_pair_en[i]) begin
                pair_on_d[i] = 1'b0;
            end
        end
    end

    // R6 separately gated pairs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pair_on_q <= '0;
            mem_clk_pair_true <= '0;
            mem_clk_pair_comp <= '1;
        end else begin
            pair_on_q <= pair_on_d;
            mem_clk_pair_true <= pair_on_d & {NUM_PAIRS{mclk_s2_q}};
            mem_clk_pair_comp <= ~(pair_on_d & {NUM_PAIRS{mclk_s2_q}});
        end
    end

endmodule

// ---- tb/dcos_cmd_out_monitor.sv ----
// Assertion checker for the command output stage.
`timescale 1ns/1ps
module dcos_cmd_out_monitor #(parameter int NUM_PAIRS = 6) (
    input logic clk,
    input logic resetn,
    input logic mem_clk,
    input logic cmd_valid,
    input logic cmd_ready,
    input logic [NUM_PAIRS-1:0] clk_pair_en,
    input logic row_strobe_copy_a_n,
    input logic row_strobe_copy_b_n,
    input logic col_strobe_copy_a_n,
    input logic col_strobe_copy_b_n,
    input logic write_enable_copy_a_n,
    input logic write_enable_copy_b_n,
    input logic [NUM_PAIRS-1:0] mem_clk_pair_true,
    input logic [NUM_PAIRS-1:0] mem_clk_pair_comp
);
    logic mc_q;
    logic [3:0] n_q;
    logic [2:0] a_n;
    assign a_n = {row_strobe_copy_a_n, col_strobe_copy_a_n, write_enable_copy_a_n};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence take_s; cmd_valid && cmd_ready; endsequence
    sequence off_s; (clk_pair_en == '0) [*8]; endsequence
    // Counts clock edges since the memory clock was last seen rising.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mc_q <= 1'b0;
            n_q <= 4'hf;
        end else begin
            mc_q <= mem_clk;
            n_q <= (mem_clk && !mc_q) ? 4'h0 : n_q + {3'h0, n_q != 4'hf};
        end
    end
    a_copies_equal: assert property (a_n ==
        {row_strobe_copy_b_n, col_strobe_copy_b_n, write_enable_copy_b_n}) else $error("copy");
    a_reset_idle: assert property (disable iff (1'b0) !resetn |-> a_n == 3'h7)
        else $error("reset");
    a_take_busy: assert property (take_s |=> !cmd_ready ##[1:30] cmd_ready)
        else $error("launch");
    a_quarter_launch: assert property ($changed(a_n) |-> n_q inside {[4:6]})
        else $error("quarter");
    a_pair_diff: assert property (mem_clk_pair_comp == ~mem_clk_pair_true)
        else $error("pair");
    a_off_static: assert property (off_s ##1 off_s |-> mem_clk_pair_true == '0)
        else $error("off");
    a_restart_edge: assert property (|(mem_clk_pair_true & ~$past(mem_clk_pair_true))
        |-> n_q < 4'h6) else $error("restart");
endmodule
bind dcos_cmd_out dcos_cmd_out_monitor #(.NUM_PAIRS(NUM_PAIRS)) i_dcos_cmd_out_monitor (.*);

// ---- tb/dcos_dimm_model.sv ----
// Listening model of the memory modules on the command lines.
`timescale 1ns/1ps
module dcos_dimm_model (
    input logic ck,
    input logic [5:0] ln,
    output logic [2:0] got
);
    always @(posedge ck) begin
        got <= ~({ln[5], ln[3], ln[1]} | {ln[4], ln[2], ln[0]});
    end
endmodule

// ---- tb/tb_dcos_cmd_out.sv ----
// Self-checking bench for the command output stage.
`timescale 1ns/1ps
module tb_dcos_cmd_out;
    logic clk = 1, rn = 1, mc = 0, v = 0, rdy;
    logic [2:0] c = 0, got;
    logic [5:0] en = 0, pt, pc;
    wire [5:0] ln;
    int fail_count = 0, comparisons = 0;
    always #5 clk = ~clk;
    always #62.5 mc = ~mc;
    dcos_cmd_out i_dcos_cmd_out (.clk(clk), .resetn(rn), .mem_clk(mc), .cmd_valid(v), .cmd(c),
        .clk_pair_en(en), .cmd_ready(rdy), .row_strobe_copy_a_n(ln[5]),
        .row_strobe_copy_b_n(ln[4]), .col_strobe_copy_a_n(ln[3]), .col_strobe_copy_b_n(ln[2]),
        .write_enable_copy_a_n(ln[1]), .write_enable_copy_b_n(ln[0]),
        .mem_clk_pair_true(pt), .mem_clk_pair_comp(pc));
    dcos_dimm_model i_dcos_dimm_model (.ck(pt[0]), .ln(ln), .got(got));
    task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_reset(input logic b);
        v = b;
        @(negedge clk);
        v = 0;
        rn = 0;
        #1;
        chk("reset", 12'hfff, {ln, pc});
        repeat (4) @(negedge clk);
        rn = 1;
    endtask
    task automatic t_pairs();
        logic [5:0] s;
        s = 0;
        en = 6'h2a;
        repeat (40) begin
            @(negedge clk);
            s = s | pt;
        end
        chk("pairs on", 12'h02a, {6'h0, s});
        en = 0;
        repeat (20) @(negedge clk);
        chk("pairs off", 12'h03f, {pt, pc});
        en = 6'h3f;
    endtask
    task automatic t_cmd(input logic [2:0] k);
        int n;
        n = 0;
        v = 1;
        c = k;
        @(negedge clk);
        c = ~k;
        v = k[0];
        chk("ready low", 12'h000, {11'h0, rdy});
        @(negedge clk);
        v = 0;
        while (rdy !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("ready high", 12'h001, {11'h0, rdy});
        chk("lines", {6'h0, {2{~k[2]}}, {2{~k[1]}}, {2{~k[0]}}}, {6'h0, ln});
        @(posedge pt[0]);
        #1;
        chk("memory", {9'h0, k}, {9'h0, got});
        @(negedge clk);
    endtask
    initial begin
        t_reset(0);
        t_pairs();
        for (int k = 0; k < 8; k++) begin
            t_cmd(k[2:0]);
        end
        t_reset(1);
        t_cmd(3'h6);
        final_report();
    end
    initial begin
        #50000;
        fail_count++;
        final_report();
    end
endmodule
